/* hdl/acl_ctrl.sv */
// Command byte, list swapping and result information control
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module acl_ctrl
    import acl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Conversion engine events
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic [3:0] conv_index,
    input wire logic list_last,
    input wire logic list_abort,
    input wire logic list_load_ok,
    input wire logic list_restart_request,
    // Converter selections
    output logic [1:0] high_ref_select,
    output logic low_ref_select,
    output logic [5:0] input_channel_select,
    output logic conv_enable,
    output logic active_csl,
    output logic active_rvl,
    // Interrupt
    output logic irq
);
    typedef struct packed {
        acl_state_t state;
        logic [7:0] cmd1;
        logic [7:0] ctrl;
        logic [3:0] stat;
        logic [3:0] mask;
        logic [15:0] conversion_flags;
        logic end_of_list_flag;
        logic command_sequence_list;
        logic result_value_list;
        logic [1:0] intermediate_result_info;
        logic [1:0] end_of_list_result_info;
        logic [7:0] rdata;
        logic [1:0] href;
        logic lref;
        logic [5:0] chan;
    } acl_regs_t;

    acl_regs_t r;
    acl_regs_t next_r;
    logic [1:0] dec_href;
    logic dec_lref;
    logic [5:0] dec_chan;
    logic cmd_reserved;
    logic both_dbl;
    logic list_end;
    logic [3:0] ev;

    acl_cmd_check u_check (
        .cmd(r.cmd1),
        .later_ver(r.ctrl[CTL_LATER_VER]),
        .high_ref_select(dec_href),
        .low_ref_select(dec_lref),
        .input_channel_select(dec_chan),
        .reserved(cmd_reserved)
    );

    always_comb begin
        next_r = r;
        both_dbl = r.ctrl[CTL_COMMAND_LIST_BUFFER_MODE] && r.ctrl[CTL_RESULT_LIST_BUFFER_MODE];
        list_end = (r.state == ACL_RUN) && (list_abort ||
            (conv_done && list_last));
        ev = 4'h0;
        unique case (r.state)
            ACL_IDLE: begin
                if (conv_start && r.ctrl[CTL_ENABLE]) begin
                    if (cmd_reserved) begin
                        ev[ST_CMD_ERR] = 1'b1;
                        next_r.state = ACL_HALT;
                    end else begin
                        next_r.href = dec_href;
                        next_r.lref = dec_lref;
                        next_r.chan = dec_chan;
                        next_r.state = ACL_RUN;
                    end
                end
            end
            ACL_RUN: begin
                if (list_abort) begin
                    ev[ST_ABORT] = 1'b1;
                    next_r.state = ACL_IDLE;
                end else if (conv_done) begin
                    if (list_last) begin
                        ev[ST_EOL] = 1'b1;
                        next_r.end_of_list_flag = 1'b1;
                    end else if (conv_index != 4'h0) begin
                        ev[ST_CON] = 1'b1;
                        next_r.conversion_flags[conv_index] = 1'b1;
                    end
                    next_r.state = ACL_IDLE;
                end
            end
            ACL_HALT: begin
                // Stays halted until software clears the error flag
                if (!r.stat[ST_CMD_ERR]) begin
                    next_r.state = ACL_IDLE;
                end
            end
            default: next_r.state = ACL_IDLE;
        endcase
        // Info captures the list that holds the just stored result
        if (ev[ST_CON]) begin
            next_r.intermediate_result_info = {r.command_sequence_list, r.result_value_list};
        end
        if (ev[ST_EOL]) begin
            next_r.intermediate_result_info = {r.command_sequence_list, r.result_value_list};
            next_r.end_of_list_result_info = {r.command_sequence_list, r.result_value_list};
        end
        if (list_end && both_dbl) begin
            next_r.result_value_list = !r.result_value_list;
            if (list_load_ok && list_restart_request) begin
                next_r.command_sequence_list = !r.command_sequence_list;
            end
        end
        // Register writes
        if (wr) begin
            unique case (addr)
                ADDR_CMD1: begin
                    if (r.ctrl[CTL_SPECIAL_MODE_ACCESS]) begin
                        next_r.cmd1 = wdata;
                    end
                end
                ADDR_CTRL: next_r.ctrl = {3'h0, wdata[4:0]};
                ADDR_STAT: next_r.stat = r.stat & ~wdata[3:0];
                ADDR_MASK: next_r.mask = wdata[3:0];
                ADDR_CONIF_LO: begin
                    next_r.conversion_flags[7:0] =
                        next_r.conversion_flags[7:0] & ~wdata;
                end
                ADDR_CONIF_HI: begin
                    next_r.conversion_flags[15:8] =
                        next_r.conversion_flags[15:8] & ~wdata;
                end
                ADDR_FLAGS: begin
                    if (wdata[0] && !ev[ST_EOL]) begin
                        next_r.end_of_list_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Set wins over the write-one clear
        next_r.stat = next_r.stat | ev;
        // Keep a flag set in the same cycle it is cleared
        if (ev[ST_CON]) begin
            next_r.conversion_flags[conv_index] = 1'b1;
        end
        next_r.conversion_flags[0] = 1'b0;
        next_r.rdata = 8'h00;
        if (rd) begin
            unique case (addr)
                ADDR_CMD1: next_r.rdata = r.cmd1;
                ADDR_CTRL: next_r.rdata = r.ctrl;
                ADDR_STAT: next_r.rdata = {4'h0, r.stat};
                ADDR_MASK: next_r.rdata = {4'h0, r.mask};
                ADDR_IMDRI: next_r.rdata = {6'h00,
                    r.intermediate_result_info};
                ADDR_EOLRI: next_r.rdata = {6'h00,
                    r.end_of_list_result_info};
                ADDR_CONIF_LO: next_r.rdata = r.conversion_flags[7:0];
                ADDR_CONIF_HI: next_r.rdata = r.conversion_flags[15:8];
                ADDR_FLAGS: next_r.rdata = {7'h00, r.end_of_list_flag};
                default: next_r.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r.state <= ACL_IDLE;
            r.cmd1 <= CMD1_RESET;
            r.ctrl <= CTRL_RESET;
            r.stat <= STAT_RESET;
            r.mask <= MASK_RESET;
            r.conversion_flags <= 16'h0000;
            r.end_of_list_flag <= 1'b0;
            r.command_sequence_list <= 1'b0;
            r.result_value_list <= 1'b0;
            r.intermediate_result_info <= 2'h0;
            r.end_of_list_result_info <= 2'h0;
            r.rdata <= 8'h00;
            r.href <= 2'h0;
            r.lref <= 1'b0;
            r.chan <= 6'h00;
        end else begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign high_ref_select = r.href;
    assign low_ref_select = r.lref;
    assign input_channel_select = r.chan;
    assign conv_enable = r.ctrl[CTL_ENABLE] && (r.state != ACL_HALT);
    assign active_csl = r.command_sequence_list;
    assign active_rvl = r.result_value_list;
    assign irq = |(r.stat & r.mask);
endmodule

/* hdl/acl_pkg.sv */
// Constants and types for the converter command and list control block
// Summary of operation
// - A reserved command setting sets the command error flag and halts.
// - A command on an internal channel sets the command error flag only for later version high reference 11.
// - Command byte is always readable, writable only under special access.
// - Earlier versions: command bit 23 picks high reference input 0 or 1.
// - Earlier versions: command bit 22 picks low reference input 0 or 1.
// - Later version: bits 23:22 pick high reference 0..2; 11 is reserved.
// - Bits 21 to 16 select the input channel of the current conversion.
// - With both lists in double buffer mode every list end or abort swaps the result list.
// - The command list swaps at list end only with load ok and restart.
// - Intermediate info updates when a conversion flag 15..1 or end flag sets.
// - After the last command stores, end of list flag and its info update.
package acl_pkg;
    localparam logic [7:0] ADDR_CMD1 = 8'h15;
    localparam logic [7:0] ADDR_CTRL = 8'h01;
    localparam logic [7:0] ADDR_STAT = 8'h02;
    localparam logic [7:0] ADDR_MASK = 8'h03;
    localparam logic [7:0] ADDR_IMDRI = 8'h04;
    localparam logic [7:0] ADDR_EOLRI = 8'h05;
    localparam logic [7:0] ADDR_CONIF_LO = 8'h06;
    localparam logic [7:0] ADDR_CONIF_HI = 8'h07;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    // Control register fields
    localparam int CTL_SPECIAL_MODE_ACCESS = 0;
    localparam int CTL_COMMAND_LIST_BUFFER_MODE = 1;
    localparam int CTL_RESULT_LIST_BUFFER_MODE = 2;
    localparam int CTL_LATER_VER = 3;
    localparam int CTL_ENABLE = 4;
    localparam logic [7:0] CTRL_RESET = 8'h10;
    // Status (sticky) bits
    localparam int ST_CMD_ERR = 0;
    localparam int ST_EOL = 1;
    localparam int ST_CON = 2;
    localparam int ST_ABORT = 3;
    localparam logic [3:0] STAT_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [7:0] CMD1_RESET = 8'h00;
    // Command byte fields
    localparam int CMD_HREF = 7;
    localparam int CMD_LREF = 6;
    localparam int CMD_CH_LO = 0;
    localparam logic [1:0] HREF_RESERVED = 2'h3;
    // Channel coding: codes at or above this are internal channels
    localparam logic [5:0] CH_INTERNAL_BASE = 6'h20;
    localparam logic [5:0] CH_EXT_LIMIT = 6'h10;
    // Result info layout: bit 0 result list, bit 1 command list
    localparam int RI_RVL = 0;
    localparam int RI_CSL = 1;

    typedef enum logic [2:0] {
        ACL_IDLE = 3'b001,
        ACL_RUN = 3'b010,
        ACL_HALT = 3'b100
    } acl_state_t;
endpackage

/* hdl/acl_cmd_check.sv */
// Decode and reserved setting check of one conversion command byte
`timescale 1ns/1ps
module acl_cmd_check
    import acl_pkg::*;
(
    // Command
    input wire logic [7:0] cmd,
    input wire logic later_ver,
    // Decoded selection
    output logic [1:0] high_ref_select,
    output logic low_ref_select,
    output logic [5:0] input_channel_select,
    output logic reserved
);
    logic internal_ch;
    logic ch_reserved;
    logic ref_reserved;

    always_comb begin
        input_channel_select = cmd[CMD_CH_LO +: 6];
        if (later_ver) begin
            high_ref_select = cmd[CMD_HREF -: 2];
            low_ref_select = 1'b0;
        end else begin
            high_ref_select = {1'b0, cmd[CMD_HREF]};
            low_ref_select = cmd[CMD_LREF];
        end
        internal_ch = input_channel_select >= CH_INTERNAL_BASE;
        ch_reserved = !internal_ch &&
            input_channel_select >= CH_EXT_LIMIT;
        ref_reserved = later_ver && high_ref_select == HREF_RESERVED;
        reserved = ch_reserved || ref_reserved;
    end
endmodule

/* bench/acl_ctrl_props.sv */
// Concurrent checks on the command and list control ports
`timescale 1ns/1ps
module acl_ctrl_props
    import acl_pkg::*;
(
    // Clock and register port
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Engine events
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic [3:0] conv_index,
    input wire logic list_last,
    input wire logic list_abort,
    input wire logic list_load_ok,
    input wire logic list_restart_request,
    // Selections and interrupt
    input wire logic [1:0] high_ref_select,
    input wire logic low_ref_select,
    input wire logic [5:0] input_channel_select,
    input wire logic conv_enable,
    input wire logic active_csl,
    input wire logic active_rvl,
    input wire logic irq
);
    logic [7:0] ctl;
    logic [7:0] cmd;
    logic busy;
    logic rsv;
    logic go;
    logic fin;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    assign rsv = cmd[5:4] == 2'h1
        || (ctl[CTL_LATER_VER] && cmd[7:6] == HREF_RESERVED);
    assign go = !busy && conv_start && conv_enable;
    assign fin = busy && (list_abort || (conv_done && list_last))
        && ctl[CTL_COMMAND_LIST_BUFFER_MODE] && ctl[CTL_RESULT_LIST_BUFFER_MODE];
    // Shadow of control, command byte and run state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctl <= CTRL_RESET;
            cmd <= CMD1_RESET;
            busy <= 1'h0;
        end else begin
            if (wr && addr == ADDR_CTRL)
                ctl <= wdata;
            if (wr && addr == ADDR_CMD1 && ctl[CTL_SPECIAL_MODE_ACCESS])
                cmd <= wdata;
            busy <= busy ? !(conv_done || list_abort) : go && !rsv;
        end
    end
    property p_err; go && rsv |=> !conv_enable [*2]; endproperty
    a_err: assert property (p_err) else $error("no halt");
    property p_ch; go && !rsv |=> input_channel_select == cmd[5:0];
    endproperty
    a_ch: assert property (p_ch) else $error("bad channel");
    property p_old; go && !rsv && !ctl[CTL_LATER_VER] |=>
        high_ref_select == {1'h0, cmd[CMD_HREF]}
        && low_ref_select == cmd[CMD_LREF]; endproperty
    a_old: assert property (p_old) else $error("bad refs");
    property p_new; go && !rsv && ctl[CTL_LATER_VER] |=>
        high_ref_select == cmd[7:6] && !low_ref_select; endproperty
    a_new: assert property (p_new) else $error("bad href");
    property p_rvl; fin |=> $changed(active_rvl); endproperty
    a_rvl: assert property (p_rvl) else $error("no rvl swap");
    property p_keep; fin && !(list_load_ok && list_restart_request)
        |=> $stable(active_csl); endproperty
    a_keep: assert property (p_keep) else $error("csl swapped");
    property p_swap; fin && list_load_ok && list_restart_request
        |=> active_csl != $past(active_csl); endproperty
    a_swap: assert property (p_swap) else $error("no csl swap");
    property p_rd; rd && addr == ADDR_CMD1 |=> rdata == $past(cmd);
    endproperty
    a_rd: assert property (p_rd) else $error("bad cmd read");
    c_err: cover property (go && rsv);
    c_swap: cover property (fin && list_load_ok && list_restart_request);
    c_abort: cover property (fin && list_abort);
endmodule
bind acl_ctrl acl_ctrl_props u_props (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .conv_start(conv_start),
    .conv_done(conv_done), .conv_index(conv_index),
    .list_last(list_last), .list_abort(list_abort),
    .list_load_ok(list_load_ok),
    .list_restart_request(list_restart_request),
    .high_ref_select(high_ref_select),
    .low_ref_select(low_ref_select),
    .input_channel_select(input_channel_select),
    .conv_enable(conv_enable), .active_csl(active_csl),
    .active_rvl(active_rvl), .irq(irq)
);

/* bench/acl_ctrl_tb.sv */
// Self-checking bench for the command and list control block
`timescale 1ns/1ps
module acl_ctrl_tb
    import acl_pkg::*;
;
    logic clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, rd_d = 1'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, c;
    logic conv_start = 1'h0, conv_done = 1'h0, list_last = 1'h0;
    logic list_abort = 1'h0, list_load_ok = 1'h0;
    logic list_restart_request = 1'h0;
    logic [3:0] conv_index = 4'h0;
    logic [1:0] high_ref_select;
    logic [5:0] input_channel_select;
    logic low_ref_select, conv_enable, active_csl, active_rvl, irq;
    logic lat, xr, xc;
    logic [2:0] xs;
    logic [15:0] x16;
    logic [7:0] tbl [8] = '{8'h85, 8'hc3, 8'h25, 8'h15,
                            8'h80, 8'h41, 8'hc2, 8'h3f};
    logic [7:0] exp_q [$];
    int fail_count = 0;
    int check_count = 0;
    acl_ctrl uut (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .conv_start(conv_start),
        .conv_done(conv_done), .conv_index(conv_index),
        .list_last(list_last), .list_abort(list_abort),
        .list_load_ok(list_load_ok),
        .list_restart_request(list_restart_request),
        .high_ref_select(high_ref_select),
        .low_ref_select(low_ref_select),
        .input_channel_select(input_channel_select),
        .conv_enable(conv_enable), .active_csl(active_csl),
        .active_rvl(active_rvl), .irq(irq)
    );
    initial forever #50 clk = ~clk;
    task automatic chk(input logic [8:0] got, input logic [8:0] e);
        check_count++;
        if (got !== e) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        if (!w)
            exp_q.push_back(d);
        @(posedge clk);
        wr <= 1'h0;
        rd <= 1'h0;
    endtask
    task automatic ev(input logic [5:0] v, input logic [3:0] i);
        @(posedge clk);
        {conv_start, conv_done, list_last, list_abort, list_load_ok,
            list_restart_request} <= v;
        conv_index <= i;
        @(posedge clk);
        {conv_start, conv_done, list_last, list_abort} <= 4'h0;
        {list_load_ok, list_restart_request, conv_index} <= 6'h00;
        #1;
    endtask
    task automatic wrap_up;
        $display("fail_count=%0d check_count=%0d", fail_count, check_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Read data stands in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d)
            chk({1'h0, rdata},
                {1'h0, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx});
    end
    initial begin
        void'($urandom(32'hc2087a27));
        repeat (4) @(posedge clk);
        nrst <= 1'h1;
        @(negedge clk);
        chk(conv_enable, 1'h1);
        bus(1'h0, ADDR_STAT, 8'h00);
        bus(1'h0, 8'h40, 8'h00);
        bus(1'h1, ADDR_CMD1, 8'h05);
        bus(1'h0, ADDR_CMD1, CMD1_RESET);
        for (int i = 0; i < 16; i++) begin
            c = i < 8 ? tbl[i] : 8'($urandom);
            lat = i[0];
            xr = c[5:4] == 2'h1 || (lat && c[7:6] == 2'h3);
            x16 = 16'h1 << (i | 1);
            bus(1'h1, ADDR_CTRL, {4'h1, lat, 3'h1});
            bus(1'h1, ADDR_CMD1, c);
            bus(1'h0, ADDR_CMD1, c);
            ev(6'h20, 4'h0);
            chk(conv_enable, !xr);
            if (xr) begin
                bus(1'h0, ADDR_STAT, 8'h01);
            end else begin
                xs = lat ? {c[7:6], 1'h0} : {1'h0, c[7:6]};
                chk({high_ref_select, low_ref_select}, xs);
                chk(input_channel_select, c[5:0]);
                ev(6'h10, 4'(i | 1));
                bus(1'h0, ADDR_CONIF_LO, x16[7:0]);
                bus(1'h0, ADDR_CONIF_HI, x16[15:8]);
                bus(1'h0, ADDR_IMDRI, 8'h00);
                bus(1'h1, ADDR_CONIF_LO, 8'hff);
                bus(1'h1, ADDR_CONIF_HI, 8'hff);
            end
            bus(1'h1, ADDR_STAT, 8'h0f);
        end
        bus(1'h1, ADDR_CTRL, 8'h17);
        // Known legal command, the last random one may be reserved
        bus(1'h1, ADDR_CMD1, 8'h05);
        bus(1'h1, ADDR_MASK, 8'h02);
        {xc, xr} = 2'h0;
        for (int k = 0; k < 6; k++) begin
            ev(6'h20, 4'h0);
            ev(6'h10, 4'h2);
            bus(1'h0, ADDR_IMDRI, {6'h00, xc, xr});
            ev(6'h20, 4'h0);
            ev({1'h0, !k[2], !k[2], k[2], k[0], k[1]}, 4'h0);
            if (!k[2]) begin
                bus(1'h0, ADDR_EOLRI, {6'h00, xc, xr});
                bus(1'h0, ADDR_FLAGS, 8'h01);
            end
            chk(irq, !k[2]);
            xr = !xr;
            xc = xc ^ (k[0] & k[1]);
            chk({active_csl, active_rvl}, {xc, xr});
            bus(1'h1, ADDR_STAT, 8'h0f);
            bus(1'h1, ADDR_FLAGS, 8'h01);
            bus(1'h1, ADDR_CONIF_LO, 8'hff);
        end
        repeat (3) @(posedge clk);
        wrap_up();
    end
    initial begin
        #1_000_000;
        fail_count++;
        wrap_up();
    end
endmodule
